// ==== aux_bridge_pkg.sv ====
// package: register map, field layout and types for the aux io bridge
package aux_bridge_pkg;
    // register word offsets (byte address = index * 4)
    localparam logic [7:0] REG_CS0_A    = 8'h60;
    localparam logic [7:0] REG_CS0_B    = 8'h61;
    localparam logic [7:0] REG_CS1_A    = 8'h62;
    localparam logic [7:0] REG_CS1_B    = 8'h63;
    localparam logic [7:0] REG_CS2_A    = 8'h64;
    localparam logic [7:0] REG_CS2_B    = 8'h65;
    localparam logic [7:0] REG_CS3_A    = 8'h66;
    localparam logic [7:0] REG_CS3_B    = 8'h67;
    localparam logic [7:0] REG_MODE     = 8'hf0;
    localparam logic [7:0] REG_ARB      = 8'h02;
    localparam logic [7:0] REG_STATUS   = 8'h03;
    // low byte fields of cs1..cs3 (base bits live from bit 2 up, from bit 4 up for cs2/cs3 when mode bit 0 is set)
    localparam int         BIT_DISABLE  = 0;
    localparam int         BIT_WPROT    = 1;
    localparam int         BIT_MODE2    = 0;
    localparam int         BIT_REQ      = 0;
    localparam int         BIT_GNT      = 1;
    localparam int         BIT_MREQ     = 2;
    localparam logic [7:0] RST_BYTE     = 8'h00;
    localparam logic [31:0] UNMAPPED_RD = 32'h00000000;
    // strobe pulse length
    localparam int         STROBE_NS    = 120;
    localparam int         CLK_NS       = 10;
    localparam int         STROBE_CYC   = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    // serial side command codes, upper nibble
    localparam logic [3:0] CMD_CS0      = 4'h2;
    localparam logic [3:0] CMD_CS1      = 4'h3;
    localparam logic [3:0] CMD_CS2      = 4'h4;
    localparam logic [3:0] CMD_CS3      = 4'h5;

    typedef enum logic [1:0] {OWN_NONE, OWN_HOST, OWN_SERIAL} owner_type;

    // one io request from either side
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } io_req_type;

    // io answer back to a requester
    typedef struct packed {
        logic        done;
        logic        ignored;
        logic [7:0]  rdata;
    } io_rsp_type;
endpackage

// ==== aux_io_chip_select_bridge.sv ====
// aux io bridge: arbitration, select decode, strobes and config registers
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module aux_io_chip_select_bridge (
    input  wire logic                     i_clk,
    input  wire logic                     i_rst,
    // avalon-mm register slave
    input  wire logic [9:0]               i_avs_address,
    input  wire logic                     i_avs_read,
    input  wire logic                     i_avs_write,
    input  wire logic [31:0]              i_avs_writedata,
    input  wire logic [3:0]               i_avs_byteenable,
    output logic      [31:0]              o_avs_readdata,
    output logic                          o_avs_waitrequest,
    // host io request
    input  wire aux_bridge_pkg::io_req_type i_host_req,
    output var aux_bridge_pkg::io_rsp_type o_host_rsp,
    // serial side io request (addr[7:4] is the command code, addr[3:0] the aux address)
    input  wire aux_bridge_pkg::io_req_type i_serial_req,
    output var aux_bridge_pkg::io_rsp_type o_serial_rsp,
    // aux bus pins
    output logic                          o_aux_select_zero_n,
    output logic                          o_aux_select_one_hi,
    output logic                          o_aux_select_two_n,
    output logic                          o_aux_select_three_n,
    output logic                          o_aux_read_strobe_n,
    output logic                          o_aux_write_strobe_n,
    output logic      [3:0]               o_aux_addr_low,
    input  wire logic [7:0]               i_aux_data_bus,
    output logic      [7:0]               o_aux_data_bus,
    output logic                          o_aux_data_bus_oe_n
);
    import aux_bridge_pkg::*;

    logic [7:0]  cfg_ff [0:7];
    logic [7:0]  mode_ff;
    logic        wprot_ff;
    logic        req_ff;
    logic        mreq_ff;
    owner_type   owner_ff;
    logic [3:0]  sel_ff;
    logic        busy_ff;
    logic        serial_cyc_ff;
    logic        rd_stb_n_ff;
    logic        wr_stb_n_ff;
    logic        oe_n_ff;
    logic        wr_ff;
    logic [3:0]  addr_ff;
    logic [7:0]  wdata_ff;
    logic [7:0]  cnt_ff;
    logic [7:0]  din_s1_ff;
    logic [7:0]  din_s2_ff;
    logic        rd_pend_ff;
    logic [31:0] rdata_ff;
    io_rsp_type  host_rsp_ff;
    io_rsp_type  serial_rsp_ff;

    // base match helper shared by all four selects
    function automatic logic base_hit(input logic [15:0] a,
                                      input logic [7:0] lo,
                                      input logic [7:0] hi,
                                      input logic [15:0] mask);
        base_hit = ((a & mask) == ({hi, lo} & mask));
    endfunction

    // overlapping bases would light two selects at once; the lowest
    // numbered select wins so two parts never fight over the data bus
    function automatic logic [3:0] first_hit(input logic [3:0] hits);
        first_hit = hits & (~hits + 4'h1);
    endfunction

    // host decode: 16-bit io address against the base pairs
    logic [3:0] host_sel;
    logic [3:0] serial_sel;
    logic [15:0] hmask23;
    always_comb begin
        hmask23 = mode_ff[BIT_MODE2] ? 16'hfff0 : 16'hfffc;
        host_sel[0] = base_hit(i_host_req.addr, cfg_ff[0],
                               {4'h0, cfg_ff[1][3:0]}, 16'hffff);
        host_sel[1] = base_hit(i_host_req.addr, cfg_ff[2] & 8'hfc,
                               {4'h0, cfg_ff[3][3:0]}, 16'hfffc)
                      && !cfg_ff[2][BIT_DISABLE];
        host_sel[2] = base_hit(i_host_req.addr, cfg_ff[4], cfg_ff[5], hmask23)
                      && !cfg_ff[4][BIT_DISABLE];
        host_sel[3] = base_hit(i_host_req.addr, cfg_ff[6], cfg_ff[7], hmask23)
                      && !cfg_ff[6][BIT_DISABLE];
    end

    // serial decode: command code upper nibble picks the select
    always_comb begin
        serial_sel[0] = i_serial_req.addr[7:4] == CMD_CS0;
        serial_sel[1] = (i_serial_req.addr[7:4] == CMD_CS1)
                        && !cfg_ff[2][BIT_DISABLE];
        serial_sel[2] = (i_serial_req.addr[7:4] == CMD_CS2)
                        && !cfg_ff[4][BIT_DISABLE];
        serial_sel[3] = (i_serial_req.addr[7:4] == CMD_CS3)
                        && !cfg_ff[6][BIT_DISABLE];
    end

    // register bus: one wait state on reads, writes land at once
    logic [7:0] reg_idx;
    logic       cfg_hit;
    logic [2:0] cfg_i;
    assign reg_idx = i_avs_address[9:2];
    assign cfg_hit = (reg_idx >= REG_CS0_A) && (reg_idx <= REG_CS3_B);
    assign cfg_i   = 3'(reg_idx - REG_CS0_A);
    assign o_avs_waitrequest = i_avs_read && !rd_pend_ff;
    assign o_avs_readdata    = rdata_ff;

    // read path: latch data in the wait cycle
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rd_pend_ff <= 1'b0;
            rdata_ff   <= UNMAPPED_RD;
        end else begin
            rd_pend_ff <= i_avs_read && !rd_pend_ff;
            if (i_avs_read && !rd_pend_ff) begin
                if (cfg_hit) begin
                    rdata_ff <= {24'h0, cfg_ff[cfg_i]};
                end else if (reg_idx == REG_MODE) begin
                    rdata_ff <= {24'h0, mode_ff};
                end else if (reg_idx == REG_ARB) begin
                    rdata_ff <= {29'h0, mreq_ff,
                                 owner_ff == OWN_SERIAL, req_ff};
                end else if (reg_idx == REG_STATUS) begin
                    rdata_ff <= {27'h0, wprot_ff, sel_ff != 4'h0,
                                 busy_ff, owner_ff};
                end else begin
                    rdata_ff <= UNMAPPED_RD;
                end
            end
        end
    end

    // config registers; protect bit only sets, cleared by reset alone
    logic wr_lo;
    assign wr_lo = i_avs_write && i_avs_byteenable[0];
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            for (int k = 0; k < 8; k++) begin
                cfg_ff[k] <= RST_BYTE;
            end
            mode_ff  <= RST_BYTE;
            wprot_ff <= 1'b0;
            req_ff   <= 1'b0;
            mreq_ff  <= 1'b0;
        end else if (wr_lo) begin
            if (cfg_hit && (cfg_i < 3'd2 || !wprot_ff)) begin
                cfg_ff[cfg_i] <= i_avs_writedata[7:0];
            end
            if (cfg_hit && cfg_i >= 3'd2 && !cfg_i[0]
                && i_avs_writedata[BIT_WPROT]) begin
                wprot_ff <= 1'b1;
            end
            if (reg_idx == REG_MODE) begin
                mode_ff <= i_avs_writedata[7:0];
            end
            if (reg_idx == REG_ARB) begin
                req_ff  <= i_avs_writedata[BIT_REQ];
                mreq_ff <= i_avs_writedata[BIT_MREQ];
            end
        end
    end

    // arbiter: first come wins, but a priority request takes the grant from the host; host wins a tie unless priority request
    // limitation: a host request that decodes nowhere keeps the grant
    logic serial_want;
    assign serial_want = req_ff || mreq_ff;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            owner_ff <= OWN_NONE;
        end else begin
            case (owner_ff)
                OWN_NONE: begin
                    if (mreq_ff) begin
                        owner_ff <= OWN_SERIAL;
                    end else if (i_host_req.valid) begin
                        owner_ff <= OWN_HOST;
                    end else if (serial_want) begin
                        owner_ff <= OWN_SERIAL;
                    end
                end
                OWN_HOST: begin
                    if (mreq_ff) begin
                        owner_ff <= OWN_SERIAL;
                    end else if (!busy_ff && !i_host_req.valid) begin
                        owner_ff <= OWN_NONE;
                    end
                end
                OWN_SERIAL: begin
                    if (!serial_want && !busy_ff) begin
                        owner_ff <= OWN_NONE;
                    end
                end
                default: owner_ff <= OWN_NONE;
            endcase
        end
    end

    // a requester holds valid until it has seen done, so the done cycle
    // must not launch the same transfer a second time
    logic       host_hold;
    logic       serial_hold;
    logic [3:0] host_pick;
    logic       go_wr;
    assign host_hold   = host_rsp_ff.done;
    assign serial_hold = serial_rsp_ff.done;
    assign host_pick   = first_hit(host_sel);

    // cycle engine: latch the granted request and time the strobe
    logic host_go;
    logic serial_go;
    logic abort;
    assign host_go   = owner_ff == OWN_HOST && !mreq_ff && i_host_req.valid
                       && !busy_ff && !host_hold
                       && host_sel != 4'h0;
    assign serial_go = owner_ff == OWN_SERIAL && i_serial_req.valid
                       && !busy_ff && !serial_hold
                       && serial_sel != 4'h0;
    assign abort     = busy_ff && mreq_ff && !serial_cyc_ff;
    assign go_wr     = serial_go ? i_serial_req.write : i_host_req.write;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            busy_ff       <= 1'b0;
            serial_cyc_ff <= 1'b0;
            sel_ff        <= 4'h0;
            wr_ff         <= 1'b0;
            addr_ff       <= 4'h0;
            wdata_ff      <= 8'h00;
            cnt_ff        <= 8'h00;
        end else if (abort) begin
            busy_ff <= 1'b0;
            sel_ff  <= 4'h0;
        end else if (host_go || serial_go) begin
            busy_ff       <= 1'b1;
            serial_cyc_ff <= serial_go;
            sel_ff        <= serial_go ? serial_sel : host_pick;
            wr_ff         <= serial_go ? i_serial_req.write
                                       : i_host_req.write;
            addr_ff       <= serial_go ? i_serial_req.addr[3:0]
                                       : i_host_req.addr[3:0];
            wdata_ff      <= serial_go ? i_serial_req.wdata
                                       : i_host_req.wdata;
            cnt_ff        <= 8'(STROBE_CYC);
        end else if (busy_ff) begin
            if (cnt_ff == 8'h01) begin
                busy_ff <= 1'b0;
                sel_ff  <= 4'h0;
            end
            cnt_ff <= cnt_ff - 8'h01;
        end
    end

    // strobes and drive enable straight from flops: gating busy with the
    // direction flop could glitch the wrong strobe when both flip at once
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rd_stb_n_ff <= 1'b1;
            wr_stb_n_ff <= 1'b1;
            oe_n_ff     <= 1'b1;
        end else if (abort || (busy_ff && cnt_ff == 8'h01)) begin
            rd_stb_n_ff <= 1'b1;
            wr_stb_n_ff <= 1'b1;
            oe_n_ff     <= 1'b1;
        end else if (host_go || serial_go) begin
            rd_stb_n_ff <= go_wr;
            wr_stb_n_ff <= !go_wr;
            oe_n_ff     <= !go_wr;
        end
    end

    // read data pins pass two flops before use
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            din_s1_ff <= 8'h00;
            din_s2_ff <= 8'h00;
        end else begin
            din_s1_ff <= i_aux_data_bus;
            din_s2_ff <= din_s1_ff;
        end
    end

    // answers: done at strobe end; non-owner or no match is ignored
    logic finish;
    assign finish = busy_ff && !abort && cnt_ff == 8'h01;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            host_rsp_ff   <= '0;
            serial_rsp_ff <= '0;
        end else begin
            host_rsp_ff.done      <= finish && !serial_cyc_ff;
            host_rsp_ff.ignored   <= (i_host_req.valid && !busy_ff
                                      && !host_go && !host_hold)
                                     || abort;
            serial_rsp_ff.done    <= finish && serial_cyc_ff;
            serial_rsp_ff.ignored <= i_serial_req.valid && !busy_ff
                                     && !serial_go && !serial_hold;
            if (finish && !wr_ff) begin
                host_rsp_ff.rdata   <= din_s2_ff;
                serial_rsp_ff.rdata <= din_s2_ff;
            end
        end
    end
    assign o_host_rsp   = host_rsp_ff;
    assign o_serial_rsp = serial_rsp_ff;

    // pin drive; select one is the only active-high select
    assign o_aux_select_zero_n  = !sel_ff[0];
    assign o_aux_select_one_hi  =  sel_ff[1];
    assign o_aux_select_two_n   = !sel_ff[2];
    assign o_aux_select_three_n = !sel_ff[3];
    assign o_aux_read_strobe_n  = rd_stb_n_ff;
    assign o_aux_write_strobe_n = wr_stb_n_ff;
    assign o_aux_addr_low       = addr_ff;
    assign o_aux_data_bus       = wdata_ff;
    assign o_aux_data_bus_oe_n  = oe_n_ff;
endmodule
`default_nettype wire

// ==== aux_bridge_asserts.sv ====
// checker: aux bus pin relations of the bridge
`timescale 1ns/1ps
`default_nettype none
module aux_bridge_asserts (
    input wire logic                       i_clk,
    input wire logic                       i_rst,
    input wire aux_bridge_pkg::io_rsp_type o_host_rsp,
    input wire aux_bridge_pkg::io_rsp_type o_serial_rsp,
    input wire logic                       o_aux_select_zero_n,
    input wire logic                       o_aux_select_one_hi,
    input wire logic                       o_aux_select_two_n,
    input wire logic                       o_aux_select_three_n,
    input wire logic                       o_aux_read_strobe_n,
    input wire logic                       o_aux_write_strobe_n,
    input wire logic [3:0]                 o_aux_addr_low,
    input wire logic [7:0]                 o_aux_data_bus,
    input wire logic                       o_aux_data_bus_oe_n
);
    import aux_bridge_pkg::*;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    logic [3:0] sel;
    logic       stb;
    logic [4:0] len_ff;
    assign sel = {~o_aux_select_zero_n, o_aux_select_one_hi,
                  ~o_aux_select_two_n, ~o_aux_select_three_n};
    assign stb = ~o_aux_read_strobe_n | ~o_aux_write_strobe_n;
    // strobe length, restarts each strobe so an overlong pulse shows
    always_ff @(posedge i_clk) begin
        if (i_rst || !stb) begin
            len_ff <= 5'h00;
        end else begin
            len_ff <= len_ff + 5'h01;
        end
    end
    sequence strobe_end_s;
        stb ##1 !stb;
    endsequence
    sequence answer_s;
        ##[0:2] (o_host_rsp.done | o_serial_rsp.done
                 | o_host_rsp.ignored | o_serial_rsp.ignored);
    endsequence
    one_select_a: assert property ($onehot0(sel))
        else $error("more than one select active");
    rd_wr_excl_a: assert property (o_aux_read_strobe_n | o_aux_write_strobe_n)
        else $error("read and write strobes together");
    strobe_sel_a: assert property (stb |-> sel != 4'h0)
        else $error("strobe without select");
    oe_write_a: assert property (!o_aux_data_bus_oe_n |-> !o_aux_write_strobe_n)
        else $error("data driven outside write");
    sel_in_cycle_a: assert property ((sel[1] | sel[0]) |-> stb)
        else $error("select two or three outside cycle");
    addr_hold_a: assert property (stb && $past(stb) |-> $stable(o_aux_addr_low)
        && (o_aux_data_bus_oe_n || $stable(o_aux_data_bus)))
        else $error("address or data moved in strobe");
    strobe_len_a: assert property (len_ff <= STROBE_CYC)
        else $error("strobe too long");
    answer_after_a: assert property (strobe_end_s |-> answer_s)
        else $error("no answer after strobe");
    one_answer_a: assert property (!(o_host_rsp.done && o_serial_rsp.done))
        else $error("both sides answered");
endmodule
bind aux_io_chip_select_bridge aux_bridge_asserts chk (
    .i_clk(i_clk), .i_rst(i_rst), .o_host_rsp(o_host_rsp),
    .o_serial_rsp(o_serial_rsp), .o_aux_select_zero_n(o_aux_select_zero_n),
    .o_aux_select_one_hi(o_aux_select_one_hi),
    .o_aux_select_two_n(o_aux_select_two_n),
    .o_aux_select_three_n(o_aux_select_three_n),
    .o_aux_read_strobe_n(o_aux_read_strobe_n),
    .o_aux_write_strobe_n(o_aux_write_strobe_n),
    .o_aux_addr_low(o_aux_addr_low), .o_aux_data_bus(o_aux_data_bus),
    .o_aux_data_bus_oe_n(o_aux_data_bus_oe_n));
`default_nettype wire

// ==== aux_periph_model.sv ====
// far side model: four peripherals answering reads and latching writes
`timescale 1ns/1ps
`default_nettype none
module aux_periph_model (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic [3:0] i_sel,
    input  wire logic       i_rd_n,
    input  wire logic       i_wr_n,
    input  wire logic [3:0] i_addr,
    input  wire logic [7:0] i_data,
    output logic      [7:0] o_data,
    output logic      [7:0] o_wr_byte
);
    // read value names the select and address; idle bus keeps toggling
    // since nothing pulls the data lines to a level
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_data <= 8'h00;
        end else if (!i_rd_n && |i_sel) begin
            o_data <= {2'b10, i_sel[1] | i_sel[0], i_sel[2] | i_sel[0], i_addr};
        end else begin
            o_data <= ~o_data;
        end
    end
    // last byte written by the bridge
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_wr_byte <= 8'h00;
        end else if (!i_wr_n && |i_sel) begin
            o_wr_byte <= i_data;
        end
    end
endmodule
`default_nettype wire

// ==== test_aux_io_chip_select_bridge.sv ====
// testbench: register bus, host and serial io cycles through the bridge
`timescale 1ns/1ps
`default_nettype none
module test_aux_io_chip_select_bridge;
    import aux_bridge_pkg::*;
    logic       i_clk, i_rst, rd, wr, wreq, zn, one, twn, thn, rdn, wrn, oen;
    logic       ok, seen_oe;
    logic [9:0] adr;
    logic [31:0] wd, rdata, q;
    logic [3:0] xa, sel, seen_sel, seen_a;
    logic [7:0] xd_out, mdata, wbyte, rdat, seen_d;
    io_req_type hreq, sreq;
    io_rsp_type hrsp, srsp;
    int         num_errors = 0;
    int         comparisons = 0;
    assign sel = {~zn, one, ~twn, ~thn};
    aux_io_chip_select_bridge dut (.i_clk(i_clk), .i_rst(i_rst),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wd), .i_avs_byteenable(4'h1),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
        .i_host_req(hreq), .o_host_rsp(hrsp), .i_serial_req(sreq),
        .o_serial_rsp(srsp), .o_aux_select_zero_n(zn),
        .o_aux_select_one_hi(one), .o_aux_select_two_n(twn),
        .o_aux_select_three_n(thn), .o_aux_read_strobe_n(rdn),
        .o_aux_write_strobe_n(wrn), .o_aux_addr_low(xa),
        .i_aux_data_bus(oen ? mdata : xd_out), .o_aux_data_bus(xd_out),
        .o_aux_data_bus_oe_n(oen));
    aux_periph_model far (.i_clk(i_clk), .i_rst(i_rst), .i_sel(sel),
        .i_rd_n(rdn), .i_wr_n(wrn), .i_addr(xa), .i_data(xd_out),
        .o_data(mdata), .o_wr_byte(wbyte));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one avalon transfer; waitrequest and read data taken at one edge
    task automatic bus(input logic w, input logic [7:0] idx,
                       input logic [7:0] d);
        adr <= {idx, 2'b00};
        rd <= !w;
        wr <= w;
        wd <= {24'h000000, d};
        do @(posedge i_clk); while (wreq);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(q, exp);
    endtask
    // io request held until done or four ignored pulses
    task automatic io(input logic s, input logic w, input logic [15:0] a,
                      input logic [7:0] d);
        int         n;
        io_rsp_type r;
        n = 0;
        ok = 1'b0;
        seen_sel = 4'h0;
        seen_oe = 1'b0;
        if (s) sreq <= {1'b1, w, a, d};
        else hreq <= {1'b1, w, a, d};
        while (!ok && n < 4) begin
            @(posedge i_clk);
            r = s ? srsp : hrsp;
            ok = r.done;
            rdat = r.rdata;
            if (r.ignored) n++;
            if (!rdn || !wrn) begin
                seen_sel = seen_sel | sel;
                seen_a = xa;
                seen_d = xd_out;
                seen_oe = seen_oe | !oen;
            end
        end
        sreq <= '0;
        hreq <= '0;
        @(posedge i_clk);
    endtask
    task automatic ioc(input logic s, input logic w, input logic [15:0] a,
                       input logic eok, input logic [3:0] es,
                       input logic [7:0] d);
        io(s, w, a, d);
        chk(ok, eok);
        chk(seen_sel, es);
        if (eok) begin
            chk(seen_a, a[3:0]);
            chk(w ? wbyte : rdat, d);
        end
    endtask
    task automatic stop_test();
        if (num_errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge i_clk);
        num_errors++;
        stop_test();
    end
    initial begin
        i_rst = 1'b1;
        {rd, wr, adr, wd, hreq, sreq} = '0;
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        rchk(REG_CS0_A, 32'h0);
        rchk(REG_MODE, 32'h0);
        rchk(8'h10, UNMAPPED_RD);
        bus(1'b1, REG_CS0_A, 8'h80);
        bus(1'b1, REG_CS0_B, 8'h00);
        ioc(0, 1, 16'h0080, 1, 4'h8, 8'h5a);
        chk(seen_oe, 1'b1);
        ioc(0, 1, 16'h1080, 0, 4'h0, 8'h11);
        bus(1'b1, REG_CS1_B, 8'h03);
        bus(1'b1, REG_CS2_B, 8'h04);
        for (int m = 0; m < 2; m++) begin
            bus(1'b1, REG_MODE, 8'(m));
            ioc(0, 0, 16'h0302, 1, 4'h4, 8'h92);
            ioc(0, 0, m ? 16'h0408 : 16'h0403, 1, 4'h2, m ? 8'ha8 : 8'ha3);
            ioc(0, 0, m ? 16'h0413 : 16'h0408, 0, 4'h0, 8'h00);
        end
        bus(1'b1, REG_CS2_A, 8'h01);
        ioc(0, 0, 16'h0408, 0, 4'h0, 8'h00);
        bus(1'b1, REG_ARB, 8'h01);
        for (int i = 0; i < 20 && !q[BIT_GNT]; i++) bus(1'b0, REG_ARB, 8'h00);
        chk(q[BIT_GNT], 1'b1);
        ioc(0, 1, 16'h0080, 0, 4'h0, 8'h33);
        for (int c = 0; c < 4; c++) begin
            ioc(1, !c[0], {8'h00, CMD_CS0 + 4'(c), 4'hc}, c != 2,
                c == 2 ? 4'h0 : 4'h8 >> c, 8'h8c + 8'(16 * c));
        end
        bus(1'b1, REG_ARB, 8'h00);
        fork
            io(0, 1, 16'h0080, 8'h77);
            begin
                do @(negedge i_clk); while (wrn);
                @(posedge i_clk);
                bus(1'b1, REG_ARB, 8'h04);
            end
        join
        chk(ok, 1'b0);
        bus(1'b1, REG_ARB, 8'h00);
        bus(1'b1, REG_CS3_A, 8'h02);
        bus(1'b1, REG_CS1_B, 8'h07);
        rchk(REG_CS1_B, 32'h03);
        bus(1'b1, REG_CS3_A, 8'h00);
        rchk(REG_CS3_A, 32'h02);
        rchk(REG_STATUS, 32'h10);
        bus(1'b1, REG_CS2_A, 8'h00);
        ioc(0, 0, 16'h0408, 0, 4'h0, 8'h00);
        bus(1'b1, REG_CS0_A, 8'h84);
        rchk(REG_CS0_A, 32'h84);
        stop_test();
    end
endmodule
`default_nettype wire
